// ==== design/spz_params.svh ====
// Register indices, field positions, reset values and timing counts of the serial port
`ifndef SPZ_PARAMS_SVH
`define SPZ_PARAMS_SVH

// Register indices; byte address is four times the index
`define SPZ_IDX_CTRL     8'h98
`define SPZ_IDX_DATA     8'h99
`define SPZ_IDX_RELL     8'hAA
`define SPZ_IDX_RELH     8'hBA
`define SPZ_IDX_BSEL     8'hD8
`define SPZ_IDX_PCTL     8'hE0
`define SPZ_ADDR_PAD     2'h0

// Reset values
`define SPZ_CTRL_RST     8'h00
`define SPZ_DATA_RST     8'h00
`define SPZ_RELL_RST     8'hD9
`define SPZ_RELH_RST     8'h03
`define SPZ_BSEL_RST     8'h00
`define SPZ_PCTL_RST     8'h00
`define SPZ_REL_CNT_RST  10'h3D9

// Control register fields, then the BSEL and PCTL bits
`define SPZ_MODE_HI      7
`define SPZ_MODE_LO      6
`define SPZ_MP           5
`define SPZ_REN          4
`define SPZ_TB8          3
`define SPZ_RB8          2
`define SPZ_TI           1
`define SPZ_RI           0
`define SPZ_GEN_SEL      7
`define SPZ_SMOD         7

// Mode field encodings
`define SPZ_MODE_SHIFT   2'h0
`define SPZ_MODE_UART8   2'h1
`define SPZ_MODE_FIX9    2'h2
`define SPZ_MODE_VAR9    2'h3

// Timing counts
`define SPZ_SHIFT_DIV    4'hC
`define SPZ_SHIFT_LAST   (`SPZ_SHIFT_DIV - 4'h1)
`define SPZ_SHIFT_RISE   (`SPZ_SHIFT_DIV / 4'h2 - 4'h1)
`define SPZ_OVS_LAST     4'hF
`define SPZ_OVS_MID      4'h7
`define SPZ_PRESC_SLOW   2'h3
`define SPZ_PRESC_FAST   2'h1
`define SPZ_REL_TOP      10'h3FF
`define SPZ_M0_LAST_BIT  4'h7
`define SPZ_STOP_IDX8    4'h9
`define SPZ_STOP_IDX9    4'hA
`define SPZ_RX_LAST8     4'h7
`define SPZ_RX_LAST9     4'h8

`endif

// ==== design/spz_pkg.sv ====
// State types of the serial port
package spz_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_SHIFT} spz_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spz_rx_state_t;
endpackage

// ==== design/spz_serial_port.sv ====
// Serial port zero with APB register access
`timescale 1ns/1ps
`include "spz_params.svh"

module spz_serial_port
  import spz_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Baud source from timer 1
  input  wire logic        timer1_overflow,
  // Serial pins
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd
);

  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    return a == {`SPZ_ADDR_PAD, idx, `SPZ_ADDR_PAD};
  endfunction

  logic [7:0]    ctrl_reg;
  logic [7:0]    rx_buf_reg;
  logic [7:0]    rell_reg;
  logic [7:0]    relh_reg;
  logic [7:0]    bsel_reg;
  logic [7:0]    pctl_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [31:0]   rd_next;
  logic [1:0]    presc_reg;
  logic [9:0]    rel_cnt_reg;
  logic          t1_half_reg;
  spz_tx_state_t tx_state_reg;
  logic [10:0]   tx_shift_reg;
  logic [3:0]    tx_ovs_reg;
  logic [3:0]    tx_idx_reg;
  logic [3:0]    cyc_reg;
  logic          m0_rx_reg;
  logic          txd_reg;
  logic          rxd_out_reg;
  logic          rxd_oe_reg;
  spz_rx_state_t rx_state_reg;
  logic [8:0]    rx_shift_reg;
  logic [3:0]    rx_ovs_reg;
  logic [3:0]    rx_bit_reg;
  logic          rxd_prev_reg;

  // Bus phases: one wait state, the write lands on the completing edge
  wire logic bus_access = psel && penable && !pready_reg;
  wire logic commit     = psel && penable && pready_reg;
  wire logic wr         = commit && pwrite;
  wire logic hit_ctrl   = reg_hit(paddr, `SPZ_IDX_CTRL);
  wire logic hit_data   = reg_hit(paddr, `SPZ_IDX_DATA);
  wire logic hit_rell   = reg_hit(paddr, `SPZ_IDX_RELL);
  wire logic hit_relh   = reg_hit(paddr, `SPZ_IDX_RELH);
  wire logic hit_bsel   = reg_hit(paddr, `SPZ_IDX_BSEL);
  wire logic hit_pctl   = reg_hit(paddr, `SPZ_IDX_PCTL);
  wire logic mapped     = hit_ctrl || hit_data || hit_rell || hit_relh || hit_bsel || hit_pctl;
  wire logic wr_data    = wr && hit_data;

  wire logic [1:0] mode  = ctrl_reg[`SPZ_MODE_HI:`SPZ_MODE_LO];
  wire logic nine        = ctrl_reg[`SPZ_MODE_HI];
  wire logic mp          = ctrl_reg[`SPZ_MP];
  wire logic ren         = ctrl_reg[`SPZ_REN];
  wire logic ri          = ctrl_reg[`SPZ_RI];
  wire logic smod        = pctl_reg[`SPZ_SMOD];
  wire logic gen_sel     = bsel_reg[`SPZ_GEN_SEL];
  wire logic [9:0] reload = {relh_reg[1:0], rell_reg};

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd     = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe  = rxd_oe_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_next[7:0] = ctrl_reg;
    end else if (hit_data) begin
      rd_next[7:0] = rx_buf_reg;
    end else if (hit_rell) begin
      rd_next[7:0] = rell_reg;
    end else if (hit_relh) begin
      rd_next[7:0] = relh_reg;
    end else if (hit_bsel) begin
      rd_next[7:0] = {gen_sel, 7'h00};
    end else if (hit_pctl) begin
      rd_next[7:0] = {smod, 7'h00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= bus_access;
      pslverr_reg <= bus_access && !mapped;
      prdata_reg  <= (bus_access && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rell_reg <= `SPZ_RELL_RST;
      relh_reg <= `SPZ_RELH_RST;
      bsel_reg <= `SPZ_BSEL_RST;
      pctl_reg <= `SPZ_PCTL_RST;
    end else begin
      if (wr && hit_rell) begin
        rell_reg <= pwdata[7:0];
      end
      if (wr && hit_relh) begin
        relh_reg <= pwdata[7:0];
      end
      if (wr && hit_bsel) begin
        bsel_reg <= {pwdata[`SPZ_GEN_SEL], 7'h00};
      end
      if (wr && hit_pctl) begin
        pctl_reg <= {pwdata[`SPZ_SMOD], 7'h00};
      end
    end
  end

  // Baud tick at sixteen times the bit rate, derived from pclk or from the timer 1 overflow
  wire logic presc_tick = presc_reg == (smod ? `SPZ_PRESC_FAST : `SPZ_PRESC_SLOW);
  wire logic gen_tick   = presc_tick && (rel_cnt_reg == `SPZ_REL_TOP);
  wire logic t1_tick    = timer1_overflow && (smod || t1_half_reg);
  wire logic var_mode   = mode[0];
  wire logic fix_mode   = mode == `SPZ_MODE_FIX9;
  wire logic tick       = fix_mode ? presc_tick :
                          var_mode ? (gen_sel ? gen_tick : t1_tick) : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg   <= 2'h0;
      rel_cnt_reg <= `SPZ_REL_CNT_RST;
      t1_half_reg <= 1'b0;
    end else begin
      presc_reg <= presc_tick ? 2'h0 : presc_reg + 2'h1;
      if (presc_tick) begin
        rel_cnt_reg <= (rel_cnt_reg == `SPZ_REL_TOP) ? reload : rel_cnt_reg + 10'h001;
      end
      if (timer1_overflow) begin
        t1_half_reg <= !t1_half_reg;
      end
    end
  end

  // Transmit and shift-mode engine
  wire logic [3:0] stop_idx = nine ? `SPZ_STOP_IDX9 : `SPZ_STOP_IDX8;
  wire logic tx_bit_end     = tick && (tx_ovs_reg == `SPZ_OVS_LAST);
  wire logic tx_enter_stop  = (tx_state_reg == TX_UART) && tx_bit_end
                              && (tx_idx_reg == stop_idx - 4'h1);
  wire logic m0_last        = (tx_state_reg == TX_SHIFT) && (cyc_reg == `SPZ_SHIFT_LAST)
                              && (tx_idx_reg == `SPZ_M0_LAST_BIT);
  wire logic ti_set         = tx_enter_stop || (m0_last && !m0_rx_reg);
  wire logic m0_ri_set      = m0_last && m0_rx_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h000;
      tx_ovs_reg   <= 4'h0;
      tx_idx_reg   <= 4'h0;
      cyc_reg      <= 4'h0;
      m0_rx_reg    <= 1'b0;
      txd_reg      <= 1'b1;
      rxd_out_reg  <= 1'b1;
      rxd_oe_reg   <= 1'b0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_ovs_reg <= 4'h0;
          tx_idx_reg <= 4'h0;
          cyc_reg    <= 4'h0;
          if (wr_data && mode == `SPZ_MODE_SHIFT) begin
            tx_state_reg <= TX_SHIFT;
            m0_rx_reg    <= 1'b0;
            tx_shift_reg <= {3'h7, pwdata[7:0]};
            txd_reg      <= 1'b0;
            rxd_out_reg  <= pwdata[0];
            rxd_oe_reg   <= 1'b1;
          end else if (wr_data) begin
            tx_state_reg <= TX_UART;
            tx_shift_reg <= {1'b1, nine ? ctrl_reg[`SPZ_TB8] : 1'b1,
                             pwdata[7:0], 1'b0};
            txd_reg      <= 1'b0;
          end else if (mode == `SPZ_MODE_SHIFT && ren && !ri) begin
            tx_state_reg <= TX_SHIFT;
            m0_rx_reg    <= 1'b1;
            txd_reg      <= 1'b0;
            rxd_oe_reg   <= 1'b0;
          end
        end
        TX_UART: begin
          if (tick) begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
          end
          if (tx_bit_end && tx_idx_reg == stop_idx) begin
            tx_state_reg <= TX_IDLE;
            txd_reg      <= 1'b1;
          end else if (tx_bit_end) begin
            tx_idx_reg   <= tx_idx_reg + 4'h1;
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            txd_reg      <= tx_shift_reg[1];
          end
        end
        TX_SHIFT: begin
          cyc_reg <= (cyc_reg == `SPZ_SHIFT_LAST) ? 4'h0 : cyc_reg + 4'h1;
          if (cyc_reg == `SPZ_SHIFT_RISE) begin
            txd_reg <= 1'b1;
            if (m0_rx_reg) begin
              tx_shift_reg <= {tx_shift_reg[10:8], rxd_in, tx_shift_reg[7:1]};
            end
          end
          if (m0_last) begin
            tx_state_reg <= TX_IDLE;
            txd_reg      <= 1'b1;
            rxd_out_reg  <= 1'b1;
            rxd_oe_reg   <= 1'b0;
          end else if (cyc_reg == `SPZ_SHIFT_LAST) begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            txd_reg    <= 1'b0;
            if (!m0_rx_reg) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              rxd_out_reg  <= tx_shift_reg[1];
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // UART receiver, sampling once at mid-bit on the sixteen-times tick
  wire logic rx_sample     = tick && (rx_ovs_reg == `SPZ_OVS_LAST);
  wire logic [7:0] rx_data = nine ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
  wire logic rx_ninth      = nine ? rx_shift_reg[8] : rxd_in;
  // Without multiprocessor handling every frame is taken once the flag is free
  wire logic rx_accept     = !ri && (!mp || rx_ninth);
  wire logic uart_ri_set   = (rx_state_reg == RX_STOP) && rx_sample && rx_accept;
  wire logic ri_set        = uart_ri_set || m0_ri_set;
  wire logic [3:0] rx_last = nine ? `SPZ_RX_LAST9 : `SPZ_RX_LAST8;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_ovs_reg   <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_prev_reg <= rxd_in;
      if (tick) begin
        rx_ovs_reg <= rx_ovs_reg + 4'h1;
      end
      if (!ren || mode == `SPZ_MODE_SHIFT) begin
        rx_state_reg <= RX_IDLE;
      end else begin
        case (rx_state_reg)
          RX_IDLE: begin
            if (rxd_prev_reg && !rxd_in) begin
              rx_state_reg <= RX_START;
              rx_ovs_reg   <= 4'h0;
            end
          end
          RX_START: begin
            if (tick && rx_ovs_reg == `SPZ_OVS_MID) begin
              rx_ovs_reg   <= 4'h0;
              rx_bit_reg   <= 4'h0;
              // A start bit that is high again at mid-bit was a glitch
              rx_state_reg <= rxd_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_shift_reg <= {rxd_in, rx_shift_reg[8:1]};
              rx_bit_reg   <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == rx_last) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              rx_state_reg <= RX_IDLE;
            end
          end
          default: begin
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg <= `SPZ_DATA_RST;
    end else if (uart_ri_set) begin
      rx_buf_reg <= rx_data;
    end else if (m0_ri_set) begin
      rx_buf_reg <= tx_shift_reg[7:0];
    end
  end

  // Hardware sets win over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPZ_CTRL_RST;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (uart_ri_set) begin
        ctrl_reg[`SPZ_RB8] <= rx_ninth;
      end
      if (ti_set) begin
        ctrl_reg[`SPZ_TI] <= 1'b1;
      end
      if (ri_set) begin
        ctrl_reg[`SPZ_RI] <= 1'b1;
      end
    end
  end

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_reg |=> !pready_reg) else $error("pready held more than one cycle");
  a_ti_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`SPZ_TI] && !(wr && hit_ctrl) |=> ctrl_reg[`SPZ_TI])
    else $error("transmit done cleared without software");
  a_ri_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`SPZ_RI] && !(wr && hit_ctrl) |=> ctrl_reg[`SPZ_RI])
    else $error("receive done cleared without software");
  a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_reg == TX_IDLE && wr_data && mode != `SPZ_MODE_SHIFT |=> !txd_reg)
    else $error("frame did not open with a low start bit");
  a_ti_at_stop: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_reg[`SPZ_TI]) && tx_state_reg == TX_UART |-> txd_reg)
    else $error("transmit done not at start of stop bit");
  a_mp_filter: assert property (@(posedge pclk) disable iff (!presetn)
    uart_ri_set && nine && mp |=> ctrl_reg[`SPZ_RB8])
    else $error("multiprocessor frame taken with ninth bit zero");
  a_ren_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    !ren |=> rx_state_reg == RX_IDLE) else $error("receiver ran while disabled");
  a_fixed_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (fix_mode && !smod && tick) ##1 (fix_mode && !smod && !tick) [*3] ##1 (fix_mode && !smod)
    |-> tick) else $error("fixed rate tick not every four cycles");
  a_idle_lines: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_reg == TX_IDLE |-> txd_reg && !rxd_oe_reg)
    else $error("lines not released when idle");

endmodule

// ==== dv/spz_remote.sv ====
// Remote serial station facing the port's transmit and receive pins
`timescale 1ns/1ps

module spz_remote (
  // Clock and bit timing
  input  wire logic        pclk,
  input  wire logic [15:0] bit_clks,
  // Serial pins
  input  wire logic        txd,
  output logic             rxd
);
  initial rxd = 1'b1;

  // Samples mid-bit, since the start edge may lag by up to one tick
  task automatic get_frame(output logic [10:0] bits, input int n);
    bits = 11'h7FF;
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      if (i < n - 1) repeat (bit_clks) @(posedge pclk);
    end
  endtask

  // Line idles high between frames
  task automatic send_frame(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bit_clks) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask

  // Shift mode: each bit is set up while the port's clock is low, LSB first
  task automatic shift_in(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rxd <= d[i];
    end
    @(posedge txd);
    rxd <= 1'b1;
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "spz_params.svh"

module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer1_overflow;
  logic        t1_run;
  logic [1:0]  t1_cnt;
  logic        rxd_out;
  logic        rxd_oe;
  logic        txd;
  logic        remote_rxd;
  logic        rxd_line;
  logic [15:0] bit_clks;
  int          n_errors;
  int          num_checks;

  // The pin level sees the port only while it drives
  assign rxd_line = rxd_oe ? rxd_out : remote_rxd;

  spz_serial_port uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_overflow(timer1_overflow), .rxd_in(rxd_line), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd)
  );

  spz_remote remote (.pclk(pclk), .bit_clks(bit_clks), .txd(txd), .rxd(remote_rxd));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Timer 1 overflow once every four clocks while enabled
  always @(posedge pclk) begin
    t1_cnt <= t1_cnt + 2'h1;
    timer1_overflow <= t1_run && (t1_cnt == 2'h3);
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask

  task automatic reg_case();
    logic [31:0] r;
    logic        e;
    rd(`SPZ_IDX_CTRL, 8'h00);
    rd(`SPZ_IDX_DATA, 8'h00);
    rd(`SPZ_IDX_RELL, 8'hD9);
    rd(`SPZ_IDX_RELH, 8'h03);
    rd(`SPZ_IDX_BSEL, 8'h00);
    rd(`SPZ_IDX_PCTL, 8'h00);
    wr(`SPZ_IDX_BSEL, 8'hFF);
    rd(`SPZ_IDX_BSEL, 8'h80);
    apb(1'b0, 8'h10, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test registers done");
  endtask

  task automatic tx_case(input logic [7:0] ctl, input logic [7:0] d, input logic [15:0] bc,
                         input int n, input logic ninth);
    logic [10:0] fr;
    logic [10:0] exp;
    bit_clks = bc;
    exp = (n == 11) ? {1'b1, ninth, d, 1'b0} : {2'b11, d, 1'b0};
    wr(`SPZ_IDX_CTRL, ctl);
    fork
      remote.get_frame(fr, n);
      wr(`SPZ_IDX_DATA, d);
    join
    chk({21'h0, fr}, {21'h0, exp});
    rd(`SPZ_IDX_CTRL, ctl | 8'h02);
    wr(`SPZ_IDX_CTRL, ctl);
    rd(`SPZ_IDX_CTRL, ctl);
    repeat (bc) @(posedge pclk);
    $display("test transmit %h done", ctl);
  endtask

  task automatic rx_case(input logic [7:0] ctl, input logic [10:0] fr, input int n,
                         input logic [7:0] exp_ctl, input logic [7:0] exp_d);
    wr(`SPZ_IDX_CTRL, ctl);
    remote.send_frame(fr, n);
    rd(`SPZ_IDX_CTRL, exp_ctl);
    rd(`SPZ_IDX_DATA, exp_d);
    $display("test receive %h done", ctl);
  endtask

  task automatic shift_case();
    time        t_prev;
    logic [7:0] d;
    d = 8'hB4;
    t_prev = 0;
    wr(`SPZ_IDX_CTRL, 8'h00);
    wr(`SPZ_IDX_DATA, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      chk({31'h0, rxd_oe}, 32'h1);
      chk({31'h0, rxd_out}, {31'h0, d[i]});
      if (i > 0) chk(32'($time - t_prev), 32'd240);
      t_prev = $time;
    end
    repeat (12) @(posedge pclk);
    rd(`SPZ_IDX_CTRL, 8'h02);
    $display("test shift done");
  endtask

  // Shift-mode reception starts by itself once enabled with the done flag clear
  task automatic shift_rx_case();
    logic [7:0] d;
    d = 8'h6D;
    wr(`SPZ_IDX_CTRL, 8'h10);
    remote.shift_in(d);
    repeat (12) @(posedge pclk);
    rd(`SPZ_IDX_CTRL, 8'h11);
    rd(`SPZ_IDX_DATA, d);
    wr(`SPZ_IDX_CTRL, 8'h00);
    $display("test shift receive done");
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timer1_overflow = 1'b0;
    t1_run = 1'b0;
    t1_cnt = 2'h0;
    bit_clks = 16'd64;
    n_errors = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    reg_case();
    // Internal generator: bit = 64 * (1024 - 0x3FE) clocks; fixed mode must ignore it
    wr(`SPZ_IDX_RELL, 8'hFE);
    repeat (300) @(posedge pclk);
    tx_case(8'h88, 8'h5A, 16'd64, 11, 1'b1);
    wr(`SPZ_IDX_PCTL, 8'h80);
    tx_case(8'h80, 8'hC3, 16'd32, 11, 1'b0);
    wr(`SPZ_IDX_PCTL, 8'h00);
    tx_case(8'hC0, 8'h96, 16'd128, 11, 1'b0);
    rx_case(8'hF0, {2'b10, 8'h44, 1'b0}, 11, 8'hF0, 8'h00);
    rx_case(8'hF0, {2'b11, 8'h81, 1'b0}, 11, 8'hF5, 8'h81);
    wr(`SPZ_IDX_BSEL, 8'h00);
    wr(`SPZ_IDX_PCTL, 8'h80);
    t1_run <= 1'b1;
    bit_clks = 16'd64;
    rx_case(8'h50, {2'b11, 8'h3C, 1'b0}, 10, 8'h55, 8'h3C);
    rx_case(8'h40, {2'b11, 8'h77, 1'b0}, 10, 8'h40, 8'h3C);
    tx_case(8'h40, 8'hE1, 16'd64, 10, 1'b0);
    shift_case();
    shift_rx_case();
    conclude();
  end
endmodule
